// ===== dhp_host_port.sv
// Parallel host port: two bus protocols, muxed or separate address and data
`timescale 1ns/10ps
`default_nettype none
module dhp_host_port
  import dhp_pkg::*;
(
  // Clock and reset
  input  wire logic                  MCLK,
  input  wire logic                  RST,
  // Straps
  input  wire logic                  HOST_PROTOCOL_SEL,
  input  wire logic                  HOST_BUS_MULTIPLEX_SEL,
  input  wire logic                  INT_SEL_EN,
  input  wire logic [dhp_pkg::ID_W-1:0] INT_SEL_ID,
  // Host control pins
  input  wire logic                  CHIP_SEL_N,
  input  wire logic                  WRITE_OR_DATA_STROBE_N,
  input  wire logic                  READ_OR_DIRECTION,
  input  wire logic                  ADDR_LATCH_OR_STROBE,
  // Host address and data pins
  input  wire logic [dhp_pkg::ADDR_W-1:0] HOST_ADDR,
  input  wire logic [dhp_pkg::DATA_W-1:0] HOST_ADDR_DATA_IN,
  output logic      [dhp_pkg::DATA_W-1:0] HOST_ADDR_DATA_OUT,
  output logic                       HOST_ADDR_DATA_OE_N,
  // Completion pin
  output logic                       TRANSFER_DONE_OUT,
  output logic                       TRANSFER_DONE_OE_N,
  // Internal register side
  output dhp_pkg::dhp_reg_req_t      REG_REQ,
  input  wire logic [dhp_pkg::DATA_W-1:0] REG_RDATA
);

  import dhp_pkg::*;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  logic [EDGE_W-1:0] fall;
  logic              latch_mode;
  logic              muxed;
  logic              int_sel_used;
  logic              id_hit;
  logic              cs_ok;
  logic              start_wr;
  logic              start_rd;
  logic              strobe_active;
  dhp_state_t        state_reg;
  dhp_state_t        state_next;
  logic              sel_reg;
  logic              is_read_reg;
  logic              wr_pulse_reg;
  logic              rd_pulse_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              data_oe_n_reg;
  logic              done_reg;
  logic              done_oe_n_reg;

  // One detector for all three strobe lines
  dhp_fall_detect #(
    .W (EDGE_W)
  ) u_fall (
    .clk   (MCLK),
    .rst   (RST),
    .level ({READ_OR_DIRECTION, WRITE_OR_DATA_STROBE_N, ADDR_LATCH_OR_STROBE}),
    .fall  (fall)
  );

  // Mode and selection terms
  assign latch_mode   = (HOST_PROTOCOL_SEL == PROTO_LATCH);
  assign muxed        = (HOST_BUS_MULTIPLEX_SEL == BUS_MUXED);
  assign int_sel_used = muxed && INT_SEL_EN;
  assign id_hit       = (HOST_ADDR_DATA_IN[ID_LSB +: ID_W] == INT_SEL_ID);
  assign cs_ok        = !CHIP_SEL_N;

  // Access starts; in strobe style the direction line is sampled at the strobe
  assign start_wr = sel_reg && cs_ok && (latch_mode ? fall[EDGE_WDS]
                  : (fall[EDGE_WDS] && READ_OR_DIRECTION != DIR_READ));
  assign start_rd = sel_reg && cs_ok && (latch_mode ? fall[EDGE_RD]
                  : (fall[EDGE_WDS] && READ_OR_DIRECTION == DIR_READ));

  // Strobe of the current access still held low by the host
  always_comb begin
    if (!latch_mode) begin
      strobe_active = !WRITE_OR_DATA_STROBE_N;
    end else if (is_read_reg) begin
      strobe_active = !READ_OR_DIRECTION;
    end else begin
      strobe_active = !WRITE_OR_DATA_STROBE_N;
    end
  end

  // ----------------------------------------------------------------
  // Address phase
  // ----------------------------------------------------------------
  // Both protocols latch on the high-to-low transition of the same pin
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sel_reg     <= 1'b0;
      addr_reg    <= REQ_RESET.addr;
    end else if (fall[EDGE_ALE]) begin
      sel_reg <= cs_ok && (!int_sel_used || id_hit);
      if (cs_ok) begin
        // Only the low lines index a register on the shared bus
        addr_reg <= muxed ? ADDR_W'(HOST_ADDR_DATA_IN[MUX_IDX_W-1:0])
                          : HOST_ADDR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DHP_IDLE: begin
        if (start_wr) begin
          state_next = DHP_HOLD;
        end else if (start_rd) begin
          state_next = DHP_READ_WAIT;
        end
      end
      DHP_READ_WAIT: begin
        state_next = DHP_HOLD;
      end
      DHP_HOLD: begin
        // Hold completion until the host lets go of its strobe
        if (!strobe_active || CHIP_SEL_N) begin
          state_next = DHP_IDLE;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_reg <= DHP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Direction of the access in flight
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      is_read_reg <= 1'b0;
    end else if (state_reg == DHP_IDLE && (start_wr || start_rd)) begin
      is_read_reg <= start_rd && !start_wr;
    end
  end

  // Register strobes are one-cycle pulses; unselected cycles never reach them
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wr_pulse_reg <= REQ_RESET.write;
      rd_pulse_reg <= REQ_RESET.read;
      wdata_reg    <= REQ_RESET.wdata;
    end else begin
      wr_pulse_reg <= (state_reg == DHP_IDLE) && start_wr;
      rd_pulse_reg <= (state_reg == DHP_IDLE) && start_rd && !start_wr;
      if ((state_reg == DHP_IDLE) && start_wr) begin
        wdata_reg <= HOST_ADDR_DATA_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data drive
  // ----------------------------------------------------------------
  // Register file answers in the same cycle as the read pulse
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rdata_reg     <= RDATA_RESET;
      data_oe_n_reg <= OE_N_OFF;
    end else begin
      if (state_reg == DHP_READ_WAIT) begin
        rdata_reg <= REG_RDATA;
      end
      data_oe_n_reg <= (state_next == DHP_HOLD && (is_read_reg ||
                        state_reg == DHP_READ_WAIT)) ? OE_N_ON : OE_N_OFF;
    end
  end

  // ----------------------------------------------------------------
  // Completion pin
  // ----------------------------------------------------------------
  // Active level depends on protocol; driver floats while deselected
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      done_reg      <= DONE_STROBE_ACTIVE ^ 1'b1;
      done_oe_n_reg <= OE_N_OFF;
    end else begin
      if (state_next == DHP_HOLD) begin
        done_reg <= latch_mode ? DONE_LATCH_ACTIVE : DONE_STROBE_ACTIVE;
      end else begin
        done_reg <= latch_mode ? !DONE_LATCH_ACTIVE : !DONE_STROBE_ACTIVE;
      end
      done_oe_n_reg <= CHIP_SEL_N ? OE_N_OFF : OE_N_ON;
    end
  end

  assign REG_REQ             = '{write: wr_pulse_reg, read: rd_pulse_reg,
                                 addr: addr_reg, wdata: wdata_reg};
  assign HOST_ADDR_DATA_OUT  = rdata_reg;
  assign HOST_ADDR_DATA_OE_N = data_oe_n_reg;
  assign TRANSFER_DONE_OUT   = done_reg;
  assign TRANSFER_DONE_OE_N  = done_oe_n_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  chk_write_pulse: assert property (start_wr && state_reg == DHP_IDLE |=>
    REG_REQ.write && REG_REQ.wdata == $past(HOST_ADDR_DATA_IN))
    else $error("write strobe did not reach register file");
  chk_no_unsel_write: assert property (!sel_reg || CHIP_SEL_N |=> !REG_REQ.write)
    else $error("write issued while unselected");
  chk_no_unsel_read: assert property (!sel_reg || CHIP_SEL_N |=> !REG_REQ.read)
    else $error("read issued while unselected");
  chk_muxed_addr: assert property (fall[EDGE_ALE] && cs_ok && muxed |=>
    REG_REQ.addr == ADDR_W'($past(HOST_ADDR_DATA_IN[MUX_IDX_W-1:0])))
    else $error("muxed address not taken from low lines");
  chk_demux_addr: assert property (fall[EDGE_ALE] && cs_ok && !muxed |=>
    REG_REQ.addr == $past(HOST_ADDR))
    else $error("separate address not latched");
  chk_read_drive: assert property (REG_REQ.read |=> !HOST_ADDR_DATA_OE_N
    && HOST_ADDR_DATA_OUT == $past(REG_RDATA))
    else $error("read data not driven after read pulse");
  chk_ready_level: assert property (REG_REQ.write && latch_mode && !CHIP_SEL_N
    |-> TRANSFER_DONE_OUT == DONE_LATCH_ACTIVE)
    else $error("ready not high on write completion");
  chk_ack_level: assert property (REG_REQ.write && !latch_mode && !CHIP_SEL_N
    |-> TRANSFER_DONE_OUT == DONE_STROBE_ACTIVE)
    else $error("acknowledge not low on write completion");
  chk_ready_float: assert property ($past(CHIP_SEL_N) |-> TRANSFER_DONE_OE_N)
    else $error("completion pin driven while deselected");
  chk_dir_read: assert property (start_rd && !latch_mode && state_reg == DHP_IDLE
    |=> REG_REQ.read ##1 !HOST_ADDR_DATA_OE_N)
    else $error("strobe-style read did not complete");
  chk_int_select: assert property (fall[EDGE_ALE] && int_sel_used && !id_hit
    |=> !sel_reg)
    else $error("internal select accepted foreign id");

  cov_latch_write: cover property (latch_mode && REG_REQ.write);
  cov_strobe_read: cover property (!latch_mode && REG_REQ.read ##1 !HOST_ADDR_DATA_OE_N);
  cov_muxed_idsel: cover property (int_sel_used && fall[EDGE_ALE] && id_hit);
  cov_back_return: cover property (state_reg == DHP_HOLD ##1 state_reg == DHP_IDLE);

endmodule : dhp_host_port
`default_nettype wire

// ===== dhp_pkg.sv
// Shared constants and carrier types for the dual protocol host port
package dhp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 5;
  localparam int MUX_IDX_W = 4;
  localparam int ID_W      = 4;

  // ----------------------------------------------------------------
  // Strap encodings
  // ----------------------------------------------------------------
  localparam logic PROTO_LATCH  = 1'b1;
  localparam logic PROTO_STROBE = 1'b0;
  localparam logic BUS_MUXED    = 1'b1;
  localparam logic DIR_READ     = 1'b1;

  // ----------------------------------------------------------------
  // Completion levels and reset values
  // ----------------------------------------------------------------
  localparam logic DONE_LATCH_ACTIVE  = 1'b1;
  localparam logic DONE_STROBE_ACTIVE = 1'b0;
  localparam logic OE_N_OFF           = 1'b1;
  localparam logic OE_N_ON            = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;

  // Field positions on the shared address/data lines
  localparam int ID_LSB = 4;

  // Strobe bit positions in the fall detector vector
  localparam int EDGE_W   = 3;
  localparam int EDGE_ALE = 0;
  localparam int EDGE_WDS = 1;
  localparam int EDGE_RD  = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic              read;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dhp_reg_req_t;

  localparam dhp_reg_req_t REQ_RESET = '{write: 1'b0, read: 1'b0, addr: 5'h00, wdata: 8'h00};

  typedef enum logic [1:0] {
    DHP_IDLE,
    DHP_READ_WAIT,
    DHP_HOLD
  } dhp_state_t;

endpackage : dhp_pkg

// ===== dhp_fall_detect.sv
// Falling edge detector for a group of synchronous strobe inputs
`timescale 1ns/10ps
`default_nettype none
module dhp_fall_detect #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Levels in, one-cycle falls out
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] fall
);

  logic [W-1:0] prev_reg;
  logic         armed_reg;

  // Idle strobes sit high, so reset to high avoids a false fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= '1;
    end else begin
      prev_reg <= level;
    end
  end

  // A pin that idles low would look like a fall on the first edge; arm one edge later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  assign fall = armed_reg ? (prev_reg & ~level) : '0;

endmodule : dhp_fall_detect
`default_nettype wire

// ===== dhp_host_model.sv
// Host bus controller model driving the port pins from the processor side
`timescale 1ns/10ps
`default_nettype none
module dhp_host_model
  import dhp_pkg::*;
(
  // Clock and straps
  input  wire logic                     mclk,
  input  wire logic                     proto,
  input  wire logic                     mux,
  input  wire logic                     cs_tied,
  // Host pins
  output logic                          cs_n,
  output logic                          wds_n,
  output logic                          rd_dir,
  output logic                          ale,
  output logic [dhp_pkg::ADDR_W-1:0]    addr,
  output logic [dhp_pkg::DATA_W-1:0]    ad,
  // Device answers
  input  wire logic [dhp_pkg::DATA_W-1:0] ad_out,
  input  wire logic                     ad_oe_n,
  input  wire logic                     done,
  input  wire logic                     done_oe_n
);
  // Idle pins; select rests high through its pull-up
  initial begin
    cs_n   = 1'b1;
    wds_n  = 1'b1;
    rd_dir = 1'b1;
    ale    = 1'b0;
    addr   = '0;
    ad     = '0;
  end

  // One access; ok says completion came in the strobe and cleared after it
  task automatic access(input logic rd, input logic cs_lvl, input logic [4:0] a,
                        input logic [3:0] id, input logic [7:0] wd,
                        output logic [7:0] rdata, output logic ok);
    logic act;
    act   = proto ? DONE_LATCH_ACTIVE : DONE_STROBE_ACTIVE;
    ok    = 1'b0;
    rdata = 8'h00;
    @(negedge mclk);
    cs_n   = cs_lvl;
    ale    = 1'b1;
    rd_dir = proto ? 1'b1 : rd;
    addr   = a;
    ad     = mux ? {id, a[3:0]} : wd;
    @(negedge mclk);
    ale = 1'b0;
    @(negedge mclk);
    // A read releases the shared lines, so show the inverse rather than a stale value
    ad = rd ? ~ad : wd;
    if (proto && rd) rd_dir = 1'b0;
    else wds_n = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge mclk);
      #1;
      ok = (done === act) && (done_oe_n === OE_N_ON);
      // Lines the device leaves released read back as the inverse, never a stale value
      if (ok && rd) rdata = (ad_oe_n === OE_N_ON) ? ad_out : ~ad_out;
    end
    @(negedge mclk);
    wds_n  = 1'b1;
    rd_dir = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    ok = ok && (done === ~act);
    @(negedge mclk);
    cs_n = cs_tied ? 1'b0 : 1'b1;
    addr = ~addr;
    ad   = ~ad;
  endtask : access
endmodule : dhp_host_model
`default_nettype wire

// ===== dhp_host_port_tb.sv
// Self-checking bench for the dual protocol host port
`timescale 1ns/10ps
`default_nettype none
module dhp_host_port_tb;
  import dhp_pkg::*;
  logic              mclk, rst, proto, mux, isel_en, cs_tied, ok;
  logic [ID_W-1:0]   isel_id;
  logic              cs_n, wds_n, rd_dir, ale, ad_oe_n, done, done_oe_n;
  logic [ADDR_W-1:0] addr, wr_addr;
  logic [DATA_W-1:0] ad, ad_out, reg_rdata, wr_data, rd;
  logic [DATA_W-1:0] regs [32];
  dhp_reg_req_t      req;
  int                mismatches, checked, wr_count;

  // ----------------------------------------------------------------
  // Clock, register file stand-in, instances
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  // Read data is combinational from the held address
  assign reg_rdata = regs[req.addr];
  always @(posedge mclk) begin
    if (req.write === 1'b1) begin
      regs[req.addr] <= req.wdata;
      wr_addr        <= req.addr;
      wr_data        <= req.wdata;
      wr_count       <= wr_count + 1;
    end
  end

  dhp_host_port dut_u (.MCLK(mclk), .RST(rst), .HOST_PROTOCOL_SEL(proto),
    .HOST_BUS_MULTIPLEX_SEL(mux), .INT_SEL_EN(isel_en), .INT_SEL_ID(isel_id),
    .CHIP_SEL_N(cs_n), .WRITE_OR_DATA_STROBE_N(wds_n), .READ_OR_DIRECTION(rd_dir),
    .ADDR_LATCH_OR_STROBE(ale), .HOST_ADDR(addr), .HOST_ADDR_DATA_IN(ad),
    .HOST_ADDR_DATA_OUT(ad_out), .HOST_ADDR_DATA_OE_N(ad_oe_n),
    .TRANSFER_DONE_OUT(done), .TRANSFER_DONE_OE_N(done_oe_n),
    .REG_REQ(req), .REG_RDATA(reg_rdata));

  dhp_host_model host_u (.mclk(mclk), .proto(proto), .mux(mux), .cs_tied(cs_tied),
    .cs_n(cs_n), .wds_n(wds_n), .rd_dir(rd_dir), .ale(ale), .addr(addr), .ad(ad),
    .ad_out(ad_out), .ad_oe_n(ad_oe_n), .done(done), .done_oe_n(done_oe_n));

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // Write then read back in one strap setting; muxed id nibble must not reach the address
  task automatic t_mode(input logic p, input logic m);
    logic [4:0] a;
    logic [7:0] wd;
    int         w0;
    @(negedge mclk);
    proto = p;
    mux   = m;
    a     = m ? 5'h0B : 5'h16;
    wd    = {6'h17, p, m};
    w0    = wr_count;
    host_u.access(1'b0, 1'b0, a, 4'h9, wd, rd, ok);
    check(ok, 1);
    check(wr_count, w0 + 1);
    check(wr_addr, m ? {1'b0, a[3:0]} : a);
    check(wr_data, wd);
    @(posedge mclk);
    #1;
    check(done_oe_n, OE_N_OFF);
    host_u.access(1'b1, 1'b0, a, 4'h9, 8'h00, rd, ok);
    check(ok, 1);
    check(rd, wd);
    check(ad_oe_n, OE_N_OFF);
    check(wr_count, w0 + 1);
  endtask : t_mode

  // Strobes with select high are ignored
  task automatic t_refuse();
    int w0;
    @(negedge mclk);
    proto = 1'b1;
    mux   = 1'b0;
    w0    = wr_count;
    host_u.access(1'b0, 1'b1, 5'h03, 4'h0, 8'h77, rd, ok);
    check(ok, 0);
    check(wr_count, w0);
    host_u.access(1'b1, 1'b1, 5'h03, 4'h0, 8'h00, rd, ok);
    check(ok, 0);
    check(ad_oe_n, OE_N_OFF);
  endtask : t_refuse

  // Select tied low; the id nibble decides the target
  task automatic t_int_sel();
    int w0;
    @(negedge mclk);
    proto   = 1'b0;
    mux     = 1'b1;
    isel_en = 1'b1;
    isel_id = 4'h5;
    cs_tied = 1'b1;
    w0      = wr_count;
    host_u.access(1'b0, 1'b0, 5'h07, 4'h5, 8'h3C, rd, ok);
    check(ok, 1);
    check(wr_addr, 5'h07);
    host_u.access(1'b0, 1'b0, 5'h07, 4'h3, 8'hC3, rd, ok);
    check(ok, 0);
    check(wr_count, w0 + 1);
  endtask : t_int_sel

  // Watchdog sized well past the hundred or so cycles of the sequence
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    summarize();
  end

  // Main sequence
  initial begin
    rst      = 1'b1;
    proto    = 1'b1;
    mux      = 1'b0;
    isel_en  = 1'b0;
    isel_id  = 4'h0;
    cs_tied  = 1'b0;
    wr_count = 0;
    for (int i = 0; i < 32; i++) regs[i] = 8'hA0 + 8'(i);
    repeat (4) @(negedge mclk);
    check(done_oe_n, OE_N_OFF);
    check(ad_oe_n, OE_N_OFF);
    check(req, REQ_RESET);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    t_mode(1'b1, 1'b0);
    t_mode(1'b1, 1'b1);
    t_mode(1'b0, 1'b0);
    t_mode(1'b0, 1'b1);
    t_refuse();
    t_int_sel();
    summarize();
  end
endmodule : dhp_host_port_tb
`default_nettype wire
